// file: hdl/strobe_fifo_host.sv
// host that drives a strobe-timed 9-bit fifo device through its pins
`timescale 1ns/10ps
// Function
// - host resets device before first write
// - strobes high around reset rise
// - word held stable around write rise
// - shared pin is rewind in single mode
// - strobes high during rewind pulse
// - expansion input low for single mode
module strobe_fifo_host #(
  parameter int WORD_W = strobe_host_pkg::WORD_W,
  parameter int BUF_DEPTH = strobe_host_pkg::BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wr_valid,
  input wire logic [WORD_W-1:0] wr_data,
  output logic wr_ready,
  input wire logic rd_req,
  output logic rd_valid,
  output logic [WORD_W-1:0] rd_data,
  input wire logic init_req,
  input wire logic rewind_req,
  output logic busy,
  output logic dev_full,
  output logic dev_empty,
  output logic dev_half,
  output logic init_pulse_n,
  output logic wr_strobe_n,
  output logic rd_strobe_n,
  output logic first_or_rewind_n,
  output logic expansion_in_n,
  output logic [WORD_W-1:0] input_word,
  input wire logic [WORD_W-1:0] output_word,
  input wire logic full_flag_n,
  input wire logic empty_flag_n,
  input wire logic expansion_or_half_n
);
  localparam logic [7:0] C_PULSE_M1 = 8'(strobe_host_pkg::C_PULSE - 1);
  localparam logic [7:0] C_SETTLE_M1 = 8'(strobe_host_pkg::C_SETTLE - 1);

  word_stream_if #(.W(WORD_W)) in_s ();
  word_stream_if #(.W(WORD_W)) out_s ();

  strobe_host_pkg::host_st_t st_r;
  logic [strobe_host_pkg::CNT_W-1:0] cnt_r;
  logic [2:0] fl_m_r;
  logic [2:0] fl_s_r;
  logic [WORD_W-1:0] q_m_r;
  logic [WORD_W-1:0] q_s_r;
  logic init_pend_r;
  logic rt_pend_r;
  logic last_wr_r;
  logic init_seen_r;
  logic ff_s;
  logic ef_s;
  logic done;
  logic take_init;
  logic take_rt;

  assign in_s.valid = wr_valid;
  assign in_s.data = wr_data;
  assign wr_ready = in_s.ready;
  assign ff_s = fl_s_r[0];
  assign ef_s = fl_s_r[1];
  assign done = (cnt_r == strobe_host_pkg::CNT_RST);
  assign take_init = (st_r == strobe_host_pkg::ST_IDLE) && init_pend_r;
  assign take_rt = (st_r == strobe_host_pkg::ST_IDLE) && !init_pend_r && rt_pend_r;
  assign out_s.ready = (st_r == strobe_host_pkg::ST_IDLE) && !init_pend_r && !rt_pend_r
    && ff_s && (!(rd_req && ef_s) || !last_wr_r);

  word_buffer #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_s(in_s),
    .out_s(out_s)
  );

  // flag and data synchronisers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fl_m_r <= 3'h0;
      fl_s_r <= 3'h0;
      q_m_r <= strobe_host_pkg::WORD_RST;
      q_s_r <= strobe_host_pkg::WORD_RST;
    end else begin
      fl_m_r <= {expansion_or_half_n, empty_flag_n, full_flag_n};
      fl_s_r <= fl_m_r;
      q_m_r <= output_word;
      q_s_r <= q_m_r;
    end
  end

  // pending init and rewind requests, set wins over clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      init_pend_r <= 1'b1;
      rt_pend_r <= 1'b0;
    end else begin
      init_pend_r <= init_req || (init_pend_r && !take_init);
      rt_pend_r <= rewind_req || (rt_pend_r && !take_rt);
    end
  end

  // pin sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= strobe_host_pkg::ST_IDLE;
      cnt_r <= strobe_host_pkg::CNT_RST;
      init_pulse_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      rd_strobe_n <= 1'b1;
      first_or_rewind_n <= 1'b1;
      input_word <= strobe_host_pkg::WORD_RST;
      last_wr_r <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= strobe_host_pkg::WORD_RST;
    end else begin
      rd_valid <= 1'b0;
      if (!done) begin
        cnt_r <= cnt_r - 1'b1;
      end
      unique case (st_r)
        strobe_host_pkg::ST_IDLE: begin
          if (take_init) begin
            init_pulse_n <= 1'b0;
            cnt_r <= C_PULSE_M1;
            st_r <= strobe_host_pkg::ST_INIT_LO;
          end else if (take_rt) begin
            first_or_rewind_n <= 1'b0;
            cnt_r <= C_PULSE_M1;
            st_r <= strobe_host_pkg::ST_RT_LO;
          end else if (out_s.valid && out_s.ready) begin
            wr_strobe_n <= 1'b0;
            input_word <= out_s.data;
            last_wr_r <= 1'b1;
            cnt_r <= C_PULSE_M1;
            st_r <= strobe_host_pkg::ST_WR_LO;
          end else if (rd_req && ef_s) begin
            rd_strobe_n <= 1'b0;
            last_wr_r <= 1'b0;
            cnt_r <= C_PULSE_M1;
            st_r <= strobe_host_pkg::ST_RD_LO;
          end
        end
        strobe_host_pkg::ST_INIT_LO: begin
          if (done) begin
            init_pulse_n <= 1'b1;
            cnt_r <= C_SETTLE_M1;
            st_r <= strobe_host_pkg::ST_INIT_REC;
          end
        end
        strobe_host_pkg::ST_WR_LO: begin
          if (done) begin
            wr_strobe_n <= 1'b1;
            cnt_r <= C_SETTLE_M1;
            st_r <= strobe_host_pkg::ST_WR_HI;
          end
        end
        strobe_host_pkg::ST_RD_LO: begin
          if (done) begin
            rd_strobe_n <= 1'b1;
            rd_data <= q_s_r;
            rd_valid <= 1'b1;
            cnt_r <= C_SETTLE_M1;
            st_r <= strobe_host_pkg::ST_RD_HI;
          end
        end
        strobe_host_pkg::ST_RT_LO: begin
          if (done) begin
            first_or_rewind_n <= 1'b1;
            cnt_r <= C_SETTLE_M1;
            st_r <= strobe_host_pkg::ST_RT_REC;
          end
        end
        strobe_host_pkg::ST_INIT_REC, strobe_host_pkg::ST_WR_HI,
        strobe_host_pkg::ST_RD_HI, strobe_host_pkg::ST_RT_REC: begin
          if (done) begin
            st_r <= strobe_host_pkg::ST_IDLE;
          end
        end
        default: begin
          st_r <= strobe_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // status outputs and fixed single-device strap
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      expansion_in_n <= 1'b0;
      busy <= 1'b1;
      dev_full <= 1'b0;
      dev_empty <= 1'b1;
      dev_half <= 1'b0;
      init_seen_r <= 1'b0;
    end else begin
      expansion_in_n <= 1'b0;
      busy <= (st_r != strobe_host_pkg::ST_IDLE) || init_pend_r || rt_pend_r;
      dev_full <= !fl_s_r[0];
      dev_empty <= !fl_s_r[1];
      dev_half <= !fl_s_r[2];
      if (!init_pulse_n) begin
        init_seen_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  init_before_write_a: assert property (!init_seen_r |-> wr_strobe_n)
    else $error("write before device reset");
  init_strobes_a: assert property (!init_pulse_n |-> wr_strobe_n && rd_strobe_n)
    else $error("strobe low during reset pulse");
  init_recover_a: assert property ($rose(init_pulse_n) |-> (wr_strobe_n && rd_strobe_n)[*4])
    else $error("strobe moved inside reset recovery");
  wr_data_hold_a: assert property ($rose(wr_strobe_n) |-> ##1 $stable(input_word)[*2])
    else $error("write word changed at strobe rise");
  wr_data_setup_a: assert property (!wr_strobe_n && !$past(wr_strobe_n) |-> $stable(input_word))
    else $error("write word changed while strobe low");
  wr_not_full_a: assert property ($fell(wr_strobe_n) |-> $past(ff_s))
    else $error("write started on full device");
  rd_not_empty_a: assert property ($fell(rd_strobe_n) |-> $past(ef_s))
    else $error("read started on empty device");
  wr_width_a: assert property ($fell(wr_strobe_n) |-> (!wr_strobe_n)[*8])
    else $error("write strobe too short");
  rt_strobes_a: assert property (!first_or_rewind_n |-> wr_strobe_n && rd_strobe_n)
    else $error("strobe low during rewind");
  rt_width_a: assert property ($fell(first_or_rewind_n) |-> (!first_or_rewind_n)[*8])
    else $error("rewind pulse too short");
  single_mode_a: assert property (!expansion_in_n)
    else $error("expansion input not low");
endmodule // strobe_fifo_host

// file: hdl/strobe_host_pkg.sv
// constants and types shared by the strobe fifo host
package strobe_host_pkg;
  localparam int CLK_NS = 5;
  localparam int WORD_W = 9;
  localparam int BUF_DEPTH = 16;
  localparam int T_PULSE_NS = 120;
  localparam int T_SETTLE_NS = 140;
  localparam int T_REC_NS = 20;
  localparam int SYNC_CYC = 2;
  localparam int C_PULSE = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_REC = (T_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_SETTLE = (T_SETTLE_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + C_REC;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 9'h000;
  typedef enum logic [3:0] {
    ST_INIT_LO, ST_INIT_REC, ST_IDLE, ST_WR_LO, ST_WR_HI,
    ST_RD_LO, ST_RD_HI, ST_RT_LO, ST_RT_REC
  } host_st_t;
endpackage

// file: hdl/word_stream_if.sv
// valid/ready word stream between the host's own modules
`timescale 1ns/10ps
interface word_stream_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: hdl/word_buffer.sv
// small synchronous fifo for write words
`timescale 1ns/10ps
module word_buffer #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  word_stream_if.snk in_s,
  word_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic in_rdy_r;
  logic out_vld_r;
  logic push;
  logic pop;

  assign push = in_s.valid && in_rdy_r;
  assign pop = out_vld_r && out_s.ready;
  assign in_s.ready = in_rdy_r;
  assign out_s.valid = out_vld_r;
  assign out_s.data = mem[rp_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      in_rdy_r <= 1'b0;
      out_vld_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      in_rdy_r <= (cnt_nxt != (AW+1)'(DEPTH));
      out_vld_r <= (cnt_nxt != '0);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r] <= in_s.data;
    end
  end

  no_overflow_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (cnt_r == (AW+1)'(DEPTH)) |-> !in_rdy_r)
    else $error("buffer accepts while full");
endmodule // word_buffer

// file: test/fifo_dev_model.sv
// behavioural strobe-timed fifo device driven by the host
`timescale 1ns/10ps
module fifo_dev_model #(
  parameter int DEPTH = 8,
  parameter int DLY_NS = 10
) (
  input wire logic init_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic rt_n,
  input wire logic xi_n,
  input wire logic [8:0] d,
  output logic [8:0] q,
  output logic full_n,
  output logic empty_n,
  output logic half_n
);
  logic [8:0] mem [DEPTH];
  logic [8:0] q_r = 9'h000;
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  bit wok = 0;
  bit rok = 0;
  always @(negedge init_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
  end
  always @(negedge wr_n) wok = init_n && full_n;
  always @(posedge wr_n) begin
    if (wok) begin
      mem[wp] = d;
      wp = (wp + 1) % DEPTH;
      cnt++;
    end
    wok = 0;
  end
  always @(negedge rd_n) begin
    rok = init_n && empty_n;
    if (rok) q_r = mem[rp];
  end
  always @(posedge rd_n) begin
    if (rok) begin
      rp = (rp + 1) % DEPTH;
      cnt--;
    end
    rok = 0;
  end
  always @(negedge rt_n) begin
    rp = 0;
    cnt = wp;
  end
  // released outputs show the inverse word, never a stale copy
  assign q = (rd_n === 1'b0 && rok) ? q_r : ~q_r;
  assign #DLY_NS empty_n = (cnt != 0);
  assign #DLY_NS full_n = (cnt != DEPTH);
  // chained mode turns the pin into a marker of the last slot
  assign #DLY_NS half_n = xi_n ? (wp != DEPTH - 1) : (cnt <= DEPTH / 2);
endmodule // fifo_dev_model

// file: test/tb_top.sv
// self-checking bench for the strobe fifo host
`timescale 1ns/10ps
module tb_top;
  localparam int DEV_DEPTH = 8;
  localparam int OP_CYC = 60;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic wr_valid = 1'b0;
  logic [8:0] wr_data = 9'h000;
  logic rd_req = 1'b0;
  logic init_req = 1'b0;
  logic rewind_req = 1'b0;
  logic wr_ready, rd_valid, busy, dev_full, dev_empty, dev_half;
  logic [8:0] rd_data, input_word, output_word;
  logic init_pulse_n, wr_strobe_n, rd_strobe_n, first_or_rewind_n, expansion_in_n;
  logic full_flag_n, empty_flag_n, expansion_or_half_n;
  logic [8:0] exp_q [$];
  logic [8:0] sent [$];
  logic [15:0] lfsr = 16'h002a;
  int n_mismatch = 0;
  int checks = 0;
  int n_wr = 0;
  bit init_seen = 0;

  strobe_fifo_host dut_u (.clk_sys(clk_sys), .rstn(rstn), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_req(rd_req), .rd_valid(rd_valid),
    .rd_data(rd_data), .init_req(init_req), .rewind_req(rewind_req), .busy(busy),
    .dev_full(dev_full), .dev_empty(dev_empty), .dev_half(dev_half),
    .init_pulse_n(init_pulse_n), .wr_strobe_n(wr_strobe_n), .rd_strobe_n(rd_strobe_n),
    .first_or_rewind_n(first_or_rewind_n), .expansion_in_n(expansion_in_n),
    .input_word(input_word), .output_word(output_word), .full_flag_n(full_flag_n),
    .empty_flag_n(empty_flag_n), .expansion_or_half_n(expansion_or_half_n));

  fifo_dev_model #(.DEPTH(DEV_DEPTH)) dev_u (.init_n(init_pulse_n), .wr_n(wr_strobe_n),
    .rd_n(rd_strobe_n), .rt_n(first_or_rewind_n), .xi_n(expansion_in_n),
    .d(input_word), .q(output_word),
    .full_n(full_flag_n), .empty_n(empty_flag_n), .half_n(expansion_or_half_n));

  initial forever #2.5 clk_sys = ~clk_sys;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // one word into the host, noted as expected read data
  task automatic push;
    lfsr = lfsr_next(lfsr);
    wr_valid <= 1'b1;
    wr_data <= lfsr[8:0];
    exp_q.push_back(lfsr[8:0]);
    sent.push_back(lfsr[8:0]);
    @(posedge clk_sys);
    while (wr_ready !== 1'b1) @(posedge clk_sys);
    wr_valid <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_ops(input int n);
    repeat (n * OP_CYC) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000, "read past empty");
      else check({7'h00, rd_data}, {7'h00, exp_q.pop_front()}, "read word");
    end
  end

  always @(negedge wr_strobe_n) begin
    n_wr++;
    check({15'h0000, init_seen}, 16'h0001, "write before init");
  end

  always @(posedge init_pulse_n) begin
    if (rstn === 1'b1) begin
      init_seen = 1;
      check({14'h0000, wr_strobe_n, rd_strobe_n}, 16'h0003, "strobes at init");
    end
  end

  always @(first_or_rewind_n) begin
    if (rstn === 1'b1) check({14'h0000, wr_strobe_n, rd_strobe_n}, 16'h0003, "rewind");
  end

  initial begin
    wait_ops(80);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    wait_ops(2);
    check({15'h0000, dev_half}, 16'h0000, "half after init");
    check({15'h0000, dev_empty}, 16'h0001, "empty after init");
    check({15'h0000, expansion_in_n}, 16'h0000, "single mode");
    check({15'h0000, busy}, 16'h0000, "idle after init");
    // three words through, then a rewind replays them
    repeat (3) push();
    rd_req <= 1'b1;
    wait_ops(7);
    rd_req <= 1'b0;
    check({15'h0000, dev_empty}, 16'h0001, "drained");
    foreach (sent[i]) exp_q.push_back(sent[i]);
    rewind_req <= 1'b1;
    @(posedge clk_sys);
    rewind_req <= 1'b0;
    wait_ops(2);
    check({15'h0000, dev_empty}, 16'h0000, "rewound");
    rd_req <= 1'b1;
    wait_ops(4);
    rd_req <= 1'b0;
    check(16'(exp_q.size()), 16'h0000, "replay count");
    // fill past the device depth across the pointer wrap
    n_wr = 0;
    repeat (DEV_DEPTH + 2) push();
    wait_ops(DEV_DEPTH + 1);
    check(16'(n_wr), 16'(DEV_DEPTH), "writes while full");
    check({15'h0000, dev_full}, 16'h0001, "full");
    check({15'h0000, dev_half}, 16'h0001, "half");
    rd_req <= 1'b1;
    wait_ops(2 * DEV_DEPTH + 6);
    rd_req <= 1'b0;
    check(16'(exp_q.size()), 16'h0000, "drain count");
    check({14'h0000, dev_full, dev_half}, 16'h0000, "flags drained");
    check({15'h0000, dev_empty}, 16'h0001, "empty drained");
    // words left in the device are lost by an explicit init
    repeat (2) push();
    wait_ops(3);
    init_req <= 1'b1;
    @(posedge clk_sys);
    init_req <= 1'b0;
    wait_ops(2);
    exp_q.delete();
    check({15'h0000, dev_empty}, 16'h0001, "empty after init");
    rd_req <= 1'b1;
    wait_ops(2);
    rd_req <= 1'b0;
    report_and_stop();
  end
endmodule // tb_top
